// ==== rtl/isr_top.sv ====
// Sensor readout control: serial registers, timing, window, pixel path

// ********************************************************************
// Pixel FIFO
// ********************************************************************
module isr_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic rdy_ff, vld_ff, nxt_rdy, nxt_vld, push, pop;
	assign push = in_valid & rdy_ff;
	assign pop = vld_ff & out_ready;
	assign in_ready = rdy_ff;
	assign out_valid = vld_ff;
	assign out_data = mem_ff[rd_ff];
	// Flags are registered from the next count so they never lie
	always_comb begin
		nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		if (rst) begin
			nxt_wr = '0;
			nxt_rd = '0;
			nxt_cnt = '0;
		end
		nxt_rdy = nxt_cnt != (AW+1)'(DEPTH);
		nxt_vld = nxt_cnt != '0;
	end
	always_ff @(posedge clk) begin
		wr_ff <= nxt_wr;
		rd_ff <= nxt_rd;
		cnt_ff <= nxt_cnt;
		rdy_ff <= nxt_rdy;
		vld_ff <= nxt_vld;
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
endmodule

// ********************************************************************
// Top
// ********************************************************************
module isr_top (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ctl_cs_n,
	input wire logic ctl_sck,
	input wire logic ctl_sdi,
	output logic ctl_sdo,
	input wire logic ext_clock_in,
	input wire logic line_sync_i,
	output logic line_sync_o,
	output logic line_sync_oe_n,
	input wire logic frame_sync_i,
	output logic frame_sync_o,
	output logic frame_sync_oe_n,
	input wire logic power_down_pin,
	output logic adc_start,
	input wire logic [isr_pkg::PIX_W-1:0] pix_in,
	input wire logic pix_valid,
	output logic pix_ready,
	output logic pclk,
	output logic [isr_pkg::PIX_W-1:0] pix_out,
	output logic line_valid
);
	import isr_pkg::*;
	logic [6:0] a_in, s1_ff, s2_ff, s3_ff;
	logic cs, srise, sfall, xrise, xfall, lrise, frise, pd;
	logic [15:0] sh_ff, nxt_sh;
	logic [4:0] bc_ff, nxt_bc;
	logic [7:0] rsh_ff, nxt_rsh, rdata;
	logic sdo_ff, nxt_sdo, wr_en;
	logic [6:0] wr_addr, rd_addr;
	logic [7:0] wr_data;
	logic [7:0] mode_ff, pwr_ff, out_ff, proc_ff, gain_ff;
	logic [7:0] nxt_mode, nxt_pwr, nxt_out, nxt_proc, nxt_gain;
	logic [10:0] hs_ff, he_ff, vs_ff, ve_ff;
	logic [10:0] nxt_hs, nxt_he, nxt_vs, nxt_ve;
	logic srst_ff, nxt_srst, clr, red, slave, run;
	logic [10:0] w, h, wmax, wmin, hmax, he_eff, ve_eff;
	logic [11:0] hsum, vsum;
	logic [4:0] div_ff, nxt_div;
	logic [10:0] col_ff, row_ff, nxt_col, nxt_row;
	logic tick, fend, ls_ff, fs_ff, oe_ff, st_ff;
	logic nxt_ls, nxt_fs, nxt_oe, nxt_st;
	logic [17:0] prod;
	logic [9:0] gsat, bsub, samp_pix;
	logic keep, inwin, push, odd_r, odd_c;
	logic [13:0] bsum_ff, nxt_bsum;
	logic [9:0] blc_ff, nxt_blc, avb_ff, avg_ff, avr_ff, lum_ff;
	logic [9:0] nxt_avb, nxt_avg, nxt_avr, nxt_lum;
	logic [7:0] samp_ff, nxt_samp;
	logic signed [10:0] dlt;
	logic [11:0] lsum;
	logic otick, pop, f_valid, lv_ff, pc_ff, nxt_lv, nxt_pc, clk_lvl;
	logic [9:0] f_data, rev, po_ff, nxt_po;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	assign a_in = {power_down_pin, frame_sync_i, line_sync_i,
		ext_clock_in, ctl_sdi, ctl_sck, ctl_cs_n};
	// Stage one feeds stage two only; edges come from stages two, three
	always_ff @(posedge mclk) begin
		s1_ff <= a_in;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
	end
	assign cs = ~s2_ff[SY_CS];
	assign srise = s2_ff[SY_SCK] & ~s3_ff[SY_SCK];
	assign sfall = ~s2_ff[SY_SCK] & s3_ff[SY_SCK];
	assign xrise = s2_ff[SY_XCK] & ~s3_ff[SY_XCK];
	assign xfall = ~s2_ff[SY_XCK] & s3_ff[SY_XCK];
	assign lrise = s2_ff[SY_LS] & ~s3_ff[SY_LS];
	assign frise = s2_ff[SY_FS] & ~s3_ff[SY_FS];
	assign pd = s2_ff[SY_PD];

	// ****************************************************************
	// Serial control port
	// ****************************************************************
	assign rd_addr = {sh_ff[5:0], s2_ff[SY_SDI]};
	assign wr_addr = sh_ff[13:7];
	assign wr_data = {sh_ff[6:0], s2_ff[SY_SDI]};
	assign wr_en = cs & srise & (bc_ff == SER_LAST) & ~sh_ff[14];
	// Read data is fetched after the header byte
	always_comb begin
		case (rd_addr)
			REG_GAIN: rdata = gain_ff;
			REG_BLC: rdata = blc_ff[9:2];
			REG_AVG_B: rdata = avb_ff[9:2];
			REG_AVG_G: rdata = avg_ff[9:2];
			REG_AVG_R: rdata = avr_ff[9:2];
			REG_LUM: rdata = lum_ff[9:2];
			REG_MODE: rdata = {1'b0, mode_ff[6:0]};
			REG_PWR: rdata = pwr_ff;
			REG_OUT: rdata = out_ff;
			REG_PROC: rdata = proc_ff;
			REG_HS: rdata = hs_ff[10:3];
			REG_HE: rdata = he_ff[10:3];
			REG_VS: rdata = vs_ff[10:3];
			REG_VE: rdata = ve_ff[10:3];
			REG_WCOM: rdata = {2'b00, he_ff[2:0], hs_ff[2:0]};
			REG_VLOW: rdata = {2'b00, ve_ff[2:0], vs_ff[2:0]};
			default: rdata = 8'h00;
		endcase
	end
	// Shift on sck rise, drive sdo on sck fall; deselect aborts
	always_comb begin
		nxt_sh = sh_ff;
		nxt_bc = bc_ff;
		nxt_rsh = rsh_ff;
		nxt_sdo = sdo_ff;
		if (sys_rst | ~cs) begin
			nxt_bc = 5'h00;
			nxt_sdo = 1'b0;
		end else if (srise) begin
			nxt_sh = {sh_ff[14:0], s2_ff[SY_SDI]};
			nxt_bc = bc_ff + 5'h01;
			// Only a read frame loads data; a write shifts out zeros
			if (bc_ff == SER_HDR) begin
				nxt_rsh = sh_ff[6] ? rdata : 8'h00;
			end
		end else if (sfall && bc_ff > SER_HDR) begin
			nxt_sdo = rsh_ff[7];
			nxt_rsh = {rsh_ff[6:0], 1'b0};
		end
	end
	always_ff @(posedge mclk) begin
		sh_ff <= nxt_sh;
		bc_ff <= nxt_bc;
		rsh_ff <= nxt_rsh;
		sdo_ff <= nxt_sdo;
	end
	assign ctl_sdo = sdo_ff;

	// ****************************************************************
	// Register file and gain control
	// ****************************************************************
	assign clr = sys_rst | srst_ff;
	always_comb begin
		nxt_mode = mode_ff;
		nxt_pwr = pwr_ff;
		nxt_out = out_ff;
		nxt_proc = proc_ff;
		nxt_gain = gain_ff;
		nxt_hs = hs_ff;
		nxt_he = he_ff;
		nxt_vs = vs_ff;
		nxt_ve = ve_ff;
		nxt_srst = 1'b0;
		// Automatic gain steps once a frame towards the target level
		if (proc_ff[PROC_AGC] && fend) begin
			if (lum_ff[9:2] < AGC_TARGET - AGC_HYST && gain_ff != 8'hff) begin
				nxt_gain = gain_ff + 8'h01;
			end else if (lum_ff[9:2] > AGC_TARGET + AGC_HYST
				&& gain_ff > GAIN_DEF) begin
				nxt_gain = gain_ff - 8'h01;
			end
		end
		if (wr_en) begin
			case (wr_addr)
				REG_GAIN: nxt_gain = wr_data;
				REG_MODE: begin
					nxt_mode = {1'b0, wr_data[6:0]};
					nxt_srst = wr_data == SRST_VAL;
					// Mode change re-centres the window for the new size
					if (wr_data[6:0] != mode_ff[6:0]) begin
						nxt_hs = HS_DEF;
						nxt_he = wr_data[MODE_RED] ? HE_DEF_RED : HE_DEF;
						nxt_vs = VS_DEF;
						nxt_ve = wr_data[MODE_RED] ? VE_DEF_RED : VE_DEF;
					end
				end
				REG_PWR: nxt_pwr = wr_data;
				REG_OUT: nxt_out = wr_data;
				REG_PROC: nxt_proc = wr_data;
				REG_HS: nxt_hs = {wr_data, hs_ff[2:0]};
				REG_HE: nxt_he = {wr_data, he_ff[2:0]};
				REG_VS: nxt_vs = {wr_data, vs_ff[2:0]};
				REG_VE: nxt_ve = {wr_data, ve_ff[2:0]};
				REG_WCOM: begin
					nxt_hs = {hs_ff[10:3], wr_data[2:0]};
					nxt_he = {he_ff[10:3], wr_data[5:3]};
				end
				REG_VLOW: begin
					nxt_vs = {vs_ff[10:3], wr_data[2:0]};
					nxt_ve = {ve_ff[10:3], wr_data[5:3]};
				end
				default: ;
			endcase
		end
		if (clr) begin
			nxt_mode = CTRL_DEF;
			nxt_pwr = CTRL_DEF;
			nxt_out = CTRL_DEF;
			nxt_proc = CTRL_DEF;
			nxt_gain = GAIN_DEF;
			nxt_hs = HS_DEF;
			nxt_he = HE_DEF;
			nxt_vs = VS_DEF;
			nxt_ve = VE_DEF;
		end
	end
	always_ff @(posedge mclk) begin
		mode_ff <= nxt_mode;
		pwr_ff <= nxt_pwr;
		out_ff <= nxt_out;
		proc_ff <= nxt_proc;
		gain_ff <= nxt_gain;
		hs_ff <= nxt_hs;
		he_ff <= nxt_he;
		vs_ff <= nxt_vs;
		ve_ff <= nxt_ve;
		srst_ff <= nxt_srst;
	end

	// ****************************************************************
	// Effective window
	// ****************************************************************
	assign red = mode_ff[MODE_RED];
	assign slave = mode_ff[MODE_SLAVE];
	// Clamp size first, then clip to the array boundary
	always_comb begin
		wmax = red ? MAX_W_RED : MAX_W_FULL;
		wmin = red ? MIN_W_RED : MIN_W_FULL;
		hmax = red ? MAX_H_RED : MAX_H_FULL;
		w = (he_ff > hs_ff) ? he_ff - hs_ff : 11'h000;
		w = (w > wmax) ? wmax : ((w < wmin) ? wmin : w);
		h = (ve_ff > vs_ff) ? ve_ff - vs_ff : 11'h000;
		h = (h > hmax) ? hmax : ((h < MIN_H) ? MIN_H : h);
		hsum = {1'b0, hs_ff} + {1'b0, w};
		vsum = {1'b0, vs_ff} + {1'b0, h};
		he_eff = (hsum > BOUND_W) ? BOUND_W[10:0] : hsum[10:0];
		ve_eff = (vsum > BOUND_H) ? BOUND_H[10:0] : vsum[10:0];
	end

	// ****************************************************************
	// Timing generator
	// ****************************************************************
	assign run = ~pd & ~pwr_ff[PWR_STBY];
	// Slave takes its pixel rate from the master clock pin
	assign tick = run & (slave ? xrise : (div_ff == 5'h00));
	assign fend = (nxt_row == 11'h000) & (row_ff != 11'h000);
	// Window settings never touch these counters, so rates stay fixed
	always_comb begin
		nxt_div = (div_ff == PIX_DIV_M1) ? 5'h00 : div_ff + 5'h01;
		nxt_col = col_ff;
		nxt_row = row_ff;
		if (slave) begin
			if (frise) begin
				nxt_row = 11'h000;
				nxt_col = 11'h000;
			end else if (lrise) begin
				nxt_col = 11'h000;
				nxt_row = row_ff + 11'h001;
			end else if (tick && col_ff != LINE_TOTAL - 11'h001) begin
				nxt_col = col_ff + 11'h001;
			end
		end else if (tick) begin
			nxt_col = col_ff + 11'h001;
			if (col_ff == LINE_TOTAL - 11'h001) begin
				nxt_col = 11'h000;
				nxt_row = (row_ff == FRAME_TOTAL - 11'h001) ? 11'h000 :
					row_ff + 11'h001;
			end
		end
		nxt_ls = col_ff < LS_WIDTH;
		nxt_fs = row_ff < FS_ROWS;
		nxt_oe = slave;
		nxt_st = tick;
		if (clr | pd) begin
			nxt_div = 5'h00;
			nxt_col = 11'h000;
			nxt_row = 11'h000;
			nxt_st = 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		div_ff <= nxt_div;
		col_ff <= nxt_col;
		row_ff <= nxt_row;
		ls_ff <= nxt_ls;
		fs_ff <= nxt_fs;
		oe_ff <= nxt_oe;
		st_ff <= nxt_st;
	end
	assign line_sync_o = ls_ff;
	assign frame_sync_o = fs_ff;
	assign line_sync_oe_n = oe_ff;
	assign frame_sync_oe_n = oe_ff;
	assign adc_start = st_ff;

	// ****************************************************************
	// Pixel processing and statistics
	// ****************************************************************
	assign prod = 18'(pix_in) * 18'(gain_ff);
	assign gsat = (prod[17:14] != 4'h0) ? 10'h3ff : prod[13:4];
	// Saturate at zero so dark noise never wraps to white
	assign bsub = proc_ff[PROC_BLC_OFF] ? gsat :
		((gsat > blc_ff) ? gsat - blc_ff : 10'h000);
	assign keep = ~red | (~col_ff[1] & ~row_ff[1]);
	assign inwin = col_ff >= hs_ff && col_ff < he_eff &&
		row_ff >= vs_ff && row_ff < ve_eff;
	assign push = pix_valid & keep & inwin & run;
	assign odd_r = row_ff[0];
	assign odd_c = col_ff[0];
	assign samp_pix = bsub;
	assign dlt = $signed({1'b0, samp_pix}) - $signed({1'b0,
		(odd_r ? (odd_c ? avr_ff : avg_ff) : (odd_c ? avg_ff : avb_ff))});
	assign lsum = {2'b00, avr_ff} + {1'b0, avg_ff, 1'b0} + {2'b00, avb_ff};
	// Averages are running filters, one step per sampled pixel
	always_comb begin
		nxt_bsum = bsum_ff;
		nxt_blc = blc_ff;
		nxt_avb = avb_ff;
		nxt_avg = avg_ff;
		nxt_avr = avr_ff;
		nxt_lum = fend ? lsum[11:2] : lum_ff;
		nxt_samp = (col_ff < hs_ff) ? 8'h00 : samp_ff;
		if (pix_valid && row_ff == 11'h000 && col_ff < BLK_COLS) begin
			nxt_bsum = (col_ff == 11'h000) ? 14'(gsat) : bsum_ff + 14'(gsat);
		end
		if (row_ff == 11'h000 && col_ff == BLK_COLS) begin
			nxt_blc = bsum_ff[13:4];
		end
		if (push && samp_ff < (red ? SAMP_RED : SAMP_FULL)) begin
			nxt_samp = samp_ff + 8'h01;
			if (odd_r == odd_c) begin
				nxt_avg = avg_ff + 10'(dlt >>> 4);
			end else if (odd_r) begin
				nxt_avr = avr_ff + 10'(dlt >>> 4);
			end else begin
				nxt_avb = avb_ff + 10'(dlt >>> 4);
			end
		end
		if (clr) begin
			nxt_bsum = 14'h0000;
			nxt_blc = 10'h000;
			nxt_avb = 10'h000;
			nxt_avg = 10'h000;
			nxt_avr = 10'h000;
			nxt_lum = 10'h000;
			nxt_samp = 8'h00;
		end
	end
	always_ff @(posedge mclk) begin
		bsum_ff <= nxt_bsum;
		blc_ff <= nxt_blc;
		avb_ff <= nxt_avb;
		avg_ff <= nxt_avg;
		avr_ff <= nxt_avr;
		lum_ff <= nxt_lum;
		samp_ff <= nxt_samp;
	end

	isr_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_D)) u_fifo (
		.clk(mclk),
		.rst(clr),
		.in_valid(push),
		.in_data(bsub),
		.in_ready(pix_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(pop)
	);

	// ****************************************************************
	// Output port
	// ****************************************************************
	for (genvar i = 0; i < PIX_W; i++) begin : g_rev
		assign rev[i] = f_data[PIX_W - 1 - i];
	end
	// Data moves with the pclk rise, or with the pclk fall when out_ff[OUT_EDGE] is set
	assign otick = run & (slave ? (out_ff[OUT_EDGE] ? xfall : xrise) :
		(div_ff == (out_ff[OUT_EDGE] ? PIX_HALF : 5'h00)));
	assign pop = otick & f_valid;
	assign clk_lvl = slave ? s2_ff[SY_XCK] : (div_ff < PIX_HALF);
	always_comb begin
		nxt_po = pop ? (out_ff[OUT_SWAP] ? rev : f_data) : po_ff;
		nxt_lv = otick ? f_valid : lv_ff;
		nxt_pc = clk_lvl & run & (~out_ff[OUT_QUAL] | lv_ff);
		if (clr | ~run) begin
			nxt_po = 10'h000;
			nxt_lv = 1'b0;
			nxt_pc = 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		po_ff <= nxt_po;
		lv_ff <= nxt_lv;
		pc_ff <= nxt_pc;
	end
	assign pix_out = po_ff;
	assign line_valid = lv_ff;
	assign pclk = pc_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_width_limit: assert property ((he_eff - hs_ff) <= MAX_W_FULL
		&& (ve_eff - vs_ff) <= MAX_H_FULL) else $error("window too big");
	a_mode_window: assert property (wr_en && wr_addr == REG_MODE &&
		wr_data[6:0] != mode_ff[6:0] |=> hs_ff == HS_DEF && vs_ff == VS_DEF)
		else $error("window kept after mode change");
	a_soft_reset: assert property (wr_en && wr_addr == REG_MODE &&
		wr_data == SRST_VAL |=> srst_ff ##1 (gain_ff == GAIN_DEF &&
		pwr_ff == CTRL_DEF && col_ff == 11'h000))
		else $error("soft reset missed");
	a_slave_pins: assert property (slave |=> line_sync_oe_n
		&& frame_sync_oe_n) else $error("sync pins driven as slave");
	a_pd_hold: assert property (pd |=> col_ff == 11'h000
		&& row_ff == 11'h000 && !adc_start) else $error("counters run");
	a_stby_keep: assert property (pwr_ff[PWR_STBY] && !wr_en
		&& !clr |=> $stable(gain_ff) && $stable(hs_ff) && !adc_start)
		else $error("standby lost state");
	a_swap_order: assert property (pop && out_ff[OUT_SWAP] && !clr
		|=> pix_out[0] == $past(f_data[PIX_W-1])
		&& pix_out[PIX_W-1] == $past(f_data[0])) else $error("bad swap");
	a_blc_sub: assert property (push && !proc_ff[PROC_BLC_OFF]
		&& gsat >= blc_ff |-> 11'(bsub) + 11'(blc_ff) == 11'(gsat))
		else $error("black level not removed");
	a_sub_sample: assert property (push && red
		|-> !col_ff[1] && !row_ff[1]) else $error("dropped pixel sent");
	a_tick_space: assert property (disable iff (clr || slave)
		tick && !slave |=> !tick[*8]) else $error("pixel rate too high");
	c_red_push: cover property (push && red);
	c_slave_line: cover property (slave && lrise);
	c_soft_reset: cover property (srst_ff);
	c_swap_out: cover property (pop && out_ff[OUT_SWAP]);
endmodule

// ==== rtl/isr_pkg.sv ====
// Constants, register map and field layout of the sensor readout control
package isr_pkg;
	// ****************************************************************
	// Clock and pixel timing
	// ****************************************************************
	localparam int MCLK_MHZ = 250;
	localparam int PIX_MAX_MHZ = 12;
	// Fastest pixel rate gives the least divide, so round the divide up
	localparam int PIX_DIV = (MCLK_MHZ + PIX_MAX_MHZ - 1) / PIX_MAX_MHZ;
	localparam logic [4:0] PIX_DIV_M1 = 5'(PIX_DIV - 1);
	localparam logic [4:0] PIX_HALF = 5'(PIX_DIV / 2);
	localparam int PIX_W = 10;
	localparam int FIFO_D = 16;
	localparam logic [10:0] LINE_TOTAL = 11'h5f0;
	localparam logic [10:0] FRAME_TOTAL = 11'h41a;
	localparam logic [10:0] LS_WIDTH = 11'h020;
	localparam logic [10:0] FS_ROWS = 11'h002;
	// ****************************************************************
	// Window limits and defaults
	// ****************************************************************
	localparam logic [11:0] BOUND_W = 12'h520;
	localparam logic [11:0] BOUND_H = 12'h40c;
	localparam logic [10:0] MAX_W_FULL = 11'h50c;
	localparam logic [10:0] MAX_W_RED = 11'h500;
	localparam logic [10:0] MAX_H_FULL = 11'h400;
	localparam logic [10:0] MAX_H_RED = 11'h3c0;
	localparam logic [10:0] MIN_W_FULL = 11'h002;
	localparam logic [10:0] MIN_W_RED = 11'h004;
	localparam logic [10:0] MIN_H = 11'h004;
	localparam logic [10:0] HS_DEF = 11'h010;
	localparam logic [10:0] HE_DEF = 11'h510;
	localparam logic [10:0] HE_DEF_RED = 11'h510;
	localparam logic [10:0] VS_DEF = 11'h006;
	localparam logic [10:0] VE_DEF = 11'h406;
	localparam logic [10:0] VE_DEF_RED = 11'h3c6;
	// ****************************************************************
	// Register offsets and fields
	// ****************************************************************
	localparam logic [6:0] REG_GAIN = 7'h00;
	localparam logic [6:0] REG_BLC = 7'h01;
	localparam logic [6:0] REG_AVG_B = 7'h05;
	localparam logic [6:0] REG_AVG_G = 7'h06;
	localparam logic [6:0] REG_AVG_R = 7'h07;
	localparam logic [6:0] REG_LUM = 7'h08;
	localparam logic [6:0] REG_MODE = 7'h12;
	localparam logic [6:0] REG_PWR = 7'h14;
	localparam logic [6:0] REG_OUT = 7'h15;
	localparam logic [6:0] REG_PROC = 7'h16;
	localparam logic [6:0] REG_HS = 7'h17;
	localparam logic [6:0] REG_HE = 7'h18;
	localparam logic [6:0] REG_VS = 7'h19;
	localparam logic [6:0] REG_VE = 7'h1a;
	localparam logic [6:0] REG_WCOM = 7'h32;
	localparam logic [6:0] REG_VLOW = 7'h33;
	localparam logic [7:0] SRST_VAL = 8'h80;
	localparam int MODE_RED = 6;
	localparam int MODE_SLAVE = 0;
	localparam int PWR_STBY = 4;
	localparam int OUT_SWAP = 0;
	localparam int OUT_EDGE = 4;
	localparam int OUT_QUAL = 5;
	localparam int PROC_BLC_OFF = 0;
	localparam int PROC_AGC = 1;
	localparam logic [7:0] CTRL_DEF = 8'h00;
	localparam logic [7:0] GAIN_DEF = 8'h10;
	localparam logic [7:0] AGC_TARGET = 8'h40;
	localparam logic [7:0] AGC_HYST = 8'h08;
	localparam logic [10:0] BLK_COLS = 11'h010;
	localparam logic [7:0] SAMP_FULL = 8'h80;
	localparam logic [7:0] SAMP_RED = 8'h40;
	localparam logic [4:0] SER_HDR = 5'h07;
	localparam logic [4:0] SER_LAST = 5'h0f;
	// Positions in the synchroniser vector
	localparam int SY_CS = 0;
	localparam int SY_SCK = 1;
	localparam int SY_SDI = 2;
	localparam int SY_XCK = 3;
	localparam int SY_LS = 4;
	localparam int SY_FS = 5;
	localparam int SY_PD = 6;
endpackage

// ==== test/isr_adc_model.sv ====
// Far-side model: pixel converter answering adc_start, slave sync source
module isr_adc_model (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic adc_start,
	output logic [9:0] pix_in,
	output logic pix_valid,
	output logic ext_clock_in,
	output logic line_sync_i,
	output logic frame_sync_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] sample_ff;
	logic [2:0] dly_ff;
	int ext_cnt;
	// ************************************************************
	// Converter: answers three cycles after each start, well
	// before the next start; data is scrambled between answers
	// ************************************************************
	initial begin
		pix_in = 10'h000;
		pix_valid = 1'b0;
		sample_ff = 10'h001;
		dly_ff = 3'h0;
	end
	always @(posedge mclk) begin
		pix_valid <= 1'b0;
		pix_in <= ~pix_in;
		if (sys_rst) begin
			dly_ff <= 3'h0;
		end else if (adc_start) begin
			dly_ff <= 3'h3;
		end else if (dly_ff != 3'h0) begin
			dly_ff <= dly_ff - 3'h1;
			if (dly_ff == 3'h1) begin
				pix_valid <= 1'b1;
				pix_in <= sample_ff;
				sample_ff <= sample_ff + 10'h001;
			end
		end
	end
	// ************************************************************
	// Sync master: one shared clock, line sync per 32 clocks
	// ************************************************************
	initial begin
		ext_clock_in = 1'b0;
		line_sync_i = 1'b0;
		frame_sync_i = 1'b0;
		ext_cnt = 0;
	end
	always #32 ext_clock_in = ~ext_clock_in;
	always @(posedge ext_clock_in) begin
		ext_cnt <= ext_cnt + 1;
		line_sync_i <= (ext_cnt % 32) < 4;
		frame_sync_i <= (ext_cnt % 1024) < 32;
	end
endmodule

// ==== test/test_image_sensor_readout_control.sv ====
// Self-checking bench for the sensor readout control block
module test_image_sensor_readout_control;
	import isr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic ctl_cs_n = 1'b1;
	logic ctl_sck = 1'b0;
	logic ctl_sdi = 1'b0;
	logic power_down_pin = 1'b0;
	logic ctl_sdo, ext_clock_in, line_sync_i, frame_sync_i, adc_start;
	logic line_sync_o, line_sync_oe_n, frame_sync_o, frame_sync_oe_n;
	logic pix_valid, pix_ready, pclk, line_valid;
	logic [PIX_W-1:0] pix_in, pix_out;
	logic [7:0] rd;
	int miscompares = 0;
	int compares = 0;
	always #2 mclk = ~mclk;
	isr_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .ctl_cs_n(ctl_cs_n),
		.ctl_sck(ctl_sck), .ctl_sdi(ctl_sdi), .ctl_sdo(ctl_sdo),
		.ext_clock_in(ext_clock_in), .line_sync_i(line_sync_i),
		.line_sync_o(line_sync_o), .line_sync_oe_n(line_sync_oe_n),
		.frame_sync_i(frame_sync_i), .frame_sync_o(frame_sync_o),
		.frame_sync_oe_n(frame_sync_oe_n), .power_down_pin(power_down_pin),
		.adc_start(adc_start), .pix_in(pix_in), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .pclk(pclk), .pix_out(pix_out),
		.line_valid(line_valid));
	isr_adc_model adc_u (.mclk(mclk), .sys_rst(sys_rst),
		.adc_start(adc_start), .pix_in(pix_in), .pix_valid(pix_valid),
		.ext_clock_in(ext_clock_in), .line_sync_i(line_sync_i),
		.frame_sync_i(frame_sync_i));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("Counts: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One 16-bit frame; half period of 6 mclk keeps sync margin
	task automatic ser(input logic r, input logic [6:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic [15:0] w;
		w = {r, a, d};
		q = 8'h00;
		ctl_cs_n = 1'b0;
		repeat (6) @(negedge mclk);
		for (int i = 15; i >= 0; i--) begin
			ctl_sck = 1'b0;
			ctl_sdi = w[i];
			repeat (6) @(negedge mclk);
			if (i < 8) q[i] = ctl_sdo;
			ctl_sck = 1'b1;
			repeat (6) @(negedge mclk);
		end
		ctl_sck = 1'b0;
		repeat (6) @(negedge mclk);
		ctl_cs_n = 1'b1;
		repeat (8) @(negedge mclk);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_defaults;
		check({8'h00, line_sync_oe_n, frame_sync_oe_n}, 10'h000);
		ser(1'b1, REG_HS, 8'h00, rd);
		check(rd, HS_DEF[10:3]);
		ser(1'b1, 7'h7f, 8'h00, rd);
		check(rd, 8'h00);
		$display("defaults done");
	endtask
	task automatic t_gain_srst;
		ser(1'b0, REG_GAIN, 8'h5a, rd);
		ser(1'b1, REG_GAIN, 8'h00, rd);
		check(rd, 8'h5a);
		ser(1'b0, REG_MODE, SRST_VAL, rd);
		repeat (4096) @(negedge mclk);
		ser(1'b0, REG_MODE, SRST_VAL, rd);
		ser(1'b1, REG_GAIN, 8'h00, rd);
		check(rd, GAIN_DEF);
		$display("soft reset done");
	endtask
	task automatic t_mode_window;
		ser(1'b0, REG_HS, 8'h55, rd);
		ser(1'b0, REG_MODE, 8'h01, rd);
		check({8'h00, line_sync_oe_n, frame_sync_oe_n}, 10'h003);
		ser(1'b1, REG_HS, 8'h00, rd);
		check(rd, HS_DEF[10:3]);
		ser(1'b0, REG_MODE, 8'h00, rd);
		$display("mode and window done");
	endtask
	task automatic t_standby;
		ser(1'b0, REG_GAIN, 8'h33, rd);
		ser(1'b0, REG_PWR, 8'h10, rd);
		ser(1'b1, REG_GAIN, 8'h00, rd);
		check(rd, 8'h33);
		ser(1'b1, REG_PWR, 8'h00, rd);
		check(rd, 8'h10);
		ser(1'b0, REG_PWR, 8'h00, rd);
		$display("standby done");
	endtask
	task automatic t_power_down;
		int n;
		n = 0;
		while (pclk !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		if (n == 100) begin
			miscompares++;
			close_out();
		end
		power_down_pin = 1'b1;
		repeat (6) @(negedge mclk);
		for (int i = 0; i < 40; i++) begin
			check({8'h00, pclk, adc_start}, 10'h000);
			@(negedge mclk);
		end
		power_down_pin = 1'b0;
		$display("power down done");
	endtask
	// Wait for a rising pixel clock; the new word stands from there
	task automatic pclk_rise;
		int n;
		n = 0;
		while (pclk !== 1'b0 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		while (pclk !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 40 || pclk !== 1'b1) begin
			miscompares++;
			close_out();
		end
	endtask
	// Open the window at row 0, swap bits, expect consecutive samples
	task automatic t_pixel_out;
		logic [9:0] prev, cur;
		prev = 10'h000;
		cur = 10'h000;
		ser(1'b0, REG_GAIN, GAIN_DEF, rd);
		ser(1'b0, REG_PROC, 8'h01, rd);
		ser(1'b0, REG_VS, 8'h00, rd);
		ser(1'b0, REG_VLOW, 8'h30, rd);
		ser(1'b0, REG_OUT, 8'h01, rd);
		check({8'h00, line_sync_o, frame_sync_o}, 10'h001);
		for (int k = 0; k < 5; k++) begin
			pclk_rise();
			for (int b = 0; b < PIX_W; b++) begin
				cur[b] = pix_out[PIX_W-1-b];
			end
			check({8'h00, line_valid, pix_ready}, 10'h003);
			if (k > 0) begin
				check(cur, prev + 10'h001);
			end
			prev = cur;
		end
		ser(1'b0, REG_OUT, 8'h00, rd);
		$display("pixel output done");
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (16) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4096) @(negedge mclk);
		t_defaults();
		t_gain_srst();
		t_mode_window();
		t_standby();
		t_power_down();
		t_pixel_out();
		close_out();
	end
endmodule
